/* verilog/wopk_packer.sv */
// Packs per-macroblock weights and offsets into a 16-dword structure
//
// Summary of operation
// - Always four 8x8 slots, replicating partition values
// - 8x16: partition fills both stacked slots
// - 16x8: partition fills both side slots
// - 8x8: each slot gets its own pair
// - L0 pair low half, L1 high
// - L0 half: own, else L1, else zero
// - L1 half: own, else L0, else zero
// - Slot 0 entries at dwords 0..2
// - Slot 1 entries at dwords 4..6
// - Slot 2 entries at dwords 8..10
// - Slot 3 entries at dwords 12..14
// - Weight and offset are adjacent bytes
// - Nothing finer than 8x8 is produced
`timescale 1ns/10ps
`include "wopk_map.svh"
module wopk_packer #(
  parameter int FIFO_DEPTH = `WOPK_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Macroblock request
  input wire logic mb_valid_i,
  output logic mb_ready_o,
  input wire logic [1:0] mb_part_i,
  input wire logic [3:0] mb_l0_used_i,
  input wire logic [3:0] mb_l1_used_i,
  input wire logic [191:0] mb_weight_i,
  input wire logic [191:0] mb_offset_i,
  // Packed dword stream
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [31:0] out_data_o,
  output logic [3:0] out_index_o,
  output logic out_last_o,
  // Status
  output logic busy_o,
  output logic mode_err_o
);

  localparam int DW_W = `WOPK_DW_W;
  localparam int BUF_W = DW_W + 5;

  // Request capture and sequencing
  wopk_pkg::wopk_state_type state_ff;
  wopk_pkg::wopk_state_type nxt_state;
  logic [3:0] dw_cnt_ff;
  logic [3:0] nxt_dw_cnt;
  logic [DW_W-1:0] image_ff [`WOPK_NUM_DW];
  logic [DW_W-1:0] nxt_image [`WOPK_NUM_DW];
  logic busy_ff;
  logic mode_err_ff;
  logic accept;
  logic part_legal;

  // Buffer fill side
  logic buf_in_valid;
  logic buf_in_ready;
  logic [BUF_W-1:0] buf_in_data;
  logic [BUF_W-1:0] buf_out_data;
  logic emit_last;

  // Which partition covers an 8x8 slot (0 TL, 1 TR, 2 BL, 3 BR)
  function automatic logic [1:0] part_of_slot(
    input logic [1:0] part,
    input logic [1:0] slot
  );
    logic [1:0] p;
    p = slot;
    case (part)
      wopk_pkg::WOPK_PART_8X16: p = {1'b0, slot[0]};
      wopk_pkg::WOPK_PART_16X8: p = {1'b0, slot[1]};
      wopk_pkg::WOPK_PART_8X8: p = slot;
      default: p = slot;
    endcase
    return p;
  endfunction : part_of_slot

  // One weight/offset pair: weight high byte, offset low byte
  function automatic logic [15:0] pick_pair(
    input logic [191:0] weights,
    input logic [191:0] offsets,
    input logic [1:0] part,
    input logic [1:0] comp,
    input logic list
  );
    int idx;
    logic [15:0] pair;
    idx = ((int'(part) * `WOPK_NUM_COMP + int'(comp)) *
           `WOPK_NUM_LIST + int'(list)) * `WOPK_BYTE_W;
    pair = `WOPK_ZERO_PAIR;
    pair[`WOPK_WEIGHT_LSB +: `WOPK_BYTE_W] = weights[idx +: 8];
    pair[`WOPK_OFFSET_LSB +: `WOPK_BYTE_W] = offsets[idx +: 8];
    return pair;
  endfunction : pick_pair

  // Build one entry with the cross-list fallback
  function automatic logic [31:0] build_entry(
    input logic [191:0] weights,
    input logic [191:0] offsets,
    input logic [1:0] part,
    input logic [1:0] comp,
    input logic l0_used,
    input logic l1_used
  );
    logic [15:0] own0;
    logic [15:0] own1;
    logic [15:0] half0;
    logic [15:0] half1;
    logic [31:0] dw;
    own0 = pick_pair(weights, offsets, part, comp, 1'b0);
    own1 = pick_pair(weights, offsets, part, comp, 1'b1);
    if (l0_used) begin
      half0 = own0;
    end else if (l1_used) begin
      half0 = own1;
    end else begin
      half0 = `WOPK_ZERO_PAIR;
    end
    if (l1_used) begin
      half1 = own1;
    end else if (l0_used) begin
      half1 = own0;
    end else begin
      half1 = `WOPK_ZERO_PAIR;
    end
    dw = `WOPK_RSVD_VAL;
    dw[`WOPK_L0_LSB +: `WOPK_PAIR_W] = half0;
    dw[`WOPK_L1_LSB +: `WOPK_PAIR_W] = half1;
    return dw;
  endfunction : build_entry

  assign accept = mb_valid_i && (state_ff == wopk_pkg::WOPK_ST_IDLE);
  assign part_legal = (mb_part_i == wopk_pkg::WOPK_PART_16X8) ||
                      (mb_part_i == wopk_pkg::WOPK_PART_8X16) ||
                      (mb_part_i == wopk_pkg::WOPK_PART_8X8);

  // Whole structure is formed in one step, so the stream never waits
  // on arithmetic; costs sixteen dword registers.
  for (genvar g = 0; g < `WOPK_NUM_DW; g++) begin : g_dw
    localparam logic [1:0] SLOT = 2'(g / `WOPK_DW_PER_SLOT);
    localparam logic [1:0] COMP = 2'(g % `WOPK_DW_PER_SLOT);
    logic [1:0] part_idx;

    assign part_idx = part_of_slot(mb_part_i, SLOT);

    if (COMP == `WOPK_COMP_RSVD) begin : g_rsvd
      assign nxt_image[g] = `WOPK_RSVD_VAL;
    end else begin : g_entry
      // Slot base plus entry position gives dwords 0-2, 4-6, 8-10, 12-14
      assign nxt_image[g] = build_entry(
        mb_weight_i, mb_offset_i, part_idx, COMP,
        mb_l0_used_i[part_idx], mb_l1_used_i[part_idx]
      );
    end

    always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
        image_ff[g] <= `WOPK_RSVD_VAL;
      end else if (accept) begin
        image_ff[g] <= nxt_image[g];
      end
    end
  end

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_dw_cnt = dw_cnt_ff;
    unique case (state_ff)
      wopk_pkg::WOPK_ST_IDLE: begin
        if (mb_valid_i) begin
          nxt_state = wopk_pkg::WOPK_ST_EMIT;
          nxt_dw_cnt = `WOPK_FIRST_DW;
        end
      end
      wopk_pkg::WOPK_ST_EMIT: begin
        if (buf_in_ready) begin
          nxt_dw_cnt = dw_cnt_ff + 4'h1;
          if (dw_cnt_ff == `WOPK_LAST_DW) begin
            nxt_state = wopk_pkg::WOPK_ST_IDLE;
            nxt_dw_cnt = `WOPK_FIRST_DW;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_ff <= wopk_pkg::WOPK_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      dw_cnt_ff <= `WOPK_FIRST_DW;
    end else begin
      dw_cnt_ff <= nxt_dw_cnt;
    end
  end

  // Busy covers the emit phase only; the buffer may still hold words
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state == wopk_pkg::WOPK_ST_EMIT);
    end
  end

  // Illegal partition code is flagged and packed as 8x8
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mode_err_ff <= 1'b0;
    end else if (accept) begin
      mode_err_ff <= !part_legal;
    end
  end

  // Stream into the buffer; a full buffer stalls the sequencer
  assign emit_last = (dw_cnt_ff == `WOPK_LAST_DW);
  assign buf_in_valid = (state_ff == wopk_pkg::WOPK_ST_EMIT);
  assign buf_in_data = {emit_last, dw_cnt_ff, image_ff[dw_cnt_ff]};

  wopk_fifo #(
    .WIDTH(BUF_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in_data),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(buf_out_data)
  );

  assign out_data_o = buf_out_data[DW_W-1:0];
  assign out_index_o = buf_out_data[DW_W +: 4];
  assign out_last_o = buf_out_data[BUF_W-1];
  assign mb_ready_o = (state_ff == wopk_pkg::WOPK_ST_IDLE);
  assign busy_o = busy_ff;
  assign mode_err_o = mode_err_ff;

endmodule : wopk_packer

/* verilog/wopk_map.svh */
// Offsets, field positions and counts of the weight/offset structure
`ifndef WOPK_MAP_SVH
`define WOPK_MAP_SVH

// Structure geometry
`define WOPK_NUM_DW 16
`define WOPK_DW_PER_SLOT 4
`define WOPK_NUM_SLOT 4
`define WOPK_NUM_PART 4
`define WOPK_NUM_COMP 3
`define WOPK_NUM_LIST 2
`define WOPK_LAST_DW 4'hF
`define WOPK_FIRST_DW 4'h0

// Slot base dwords
`define WOPK_SLOT0_BASE 4'h0
`define WOPK_SLOT1_BASE 4'h4
`define WOPK_SLOT2_BASE 4'h8
`define WOPK_SLOT3_BASE 4'hC

// Entry position inside a slot
`define WOPK_COMP_LUMA 2'h0
`define WOPK_COMP_BLUE 2'h1
`define WOPK_COMP_RED 2'h2
`define WOPK_COMP_RSVD 2'h3

// Field layout of one dword entry
`define WOPK_DW_W 32
`define WOPK_PAIR_W 16
`define WOPK_BYTE_W 8
`define WOPK_L0_LSB 0
`define WOPK_L1_LSB 16
`define WOPK_WEIGHT_LSB 8
`define WOPK_OFFSET_LSB 0

// Values
`define WOPK_RSVD_VAL 32'h0000_0000
`define WOPK_ZERO_PAIR 16'h0000

// Output buffer
`define WOPK_FIFO_DEPTH 16

`endif

/* verilog/wopk_pkg.sv */
// Types shared by the weight/offset packer
package wopk_pkg;

  // Partitioning of the incoming macroblock
  typedef enum logic [1:0] {
    WOPK_PART_16X8 = 2'h0,
    WOPK_PART_8X16 = 2'h1,
    WOPK_PART_8X8 = 2'h2
  } wopk_part_type;

  // Sequencer states
  typedef enum logic {
    WOPK_ST_IDLE,
    WOPK_ST_EMIT
  } wopk_state_type;

endpackage : wopk_pkg

/* verilog/wopk_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module wopk_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells a full ring from an empty one
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wr_ptr_ff <= '0;
    end else if (push) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rd_ptr_ff <= '0;
    end else if (pop) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

endmodule : wopk_fifo

/* tb/wopk_packer_checker.sv */
// Port assertions for the packer
`timescale 1ns/10ps
module wopk_packer_checker #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Request
  input wire logic mb_valid_i,
  input wire logic mb_ready_o,
  input wire logic [1:0] mb_part_i,
  // Stream and status
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [31:0] out_data_o,
  input wire logic [3:0] out_index_o,
  input wire logic out_last_o,
  input wire logic busy_o,
  input wire logic mode_err_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_last_index: assert property (
    out_valid_o && out_last_o |-> out_index_o == 4'hF) else $error("last");
  a_rsvd_zero: assert property (
    out_valid_o && out_index_o[1:0] == 2'h3 |-> out_data_o == 32'h0000_0000)
    else $error("reserved dword not zero");
  a_word_hold: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
    && $stable(out_index_o)) else $error("word changed while stalled");
  a_index_step: assert property (
    (out_valid_o && out_ready_i && !out_last_o) ##1 out_valid_o
    |-> out_index_o == $past(out_index_o) + 4'h1) else $error("index skip");
  a_accept_busy: assert property (
    mb_valid_i && mb_ready_o |=> busy_o && !mb_ready_o) else $error("accept");
  a_ready_busy: assert property (
    mb_ready_o != busy_o) else $error("ready and busy disagree");
  a_first_word: assert property (
    mb_valid_i && mb_ready_o |-> ##2 out_valid_o) else $error("no output");
  a_err_code: assert property (
    mb_valid_i && mb_ready_o |=> mode_err_o == ($past(mb_part_i) == 2'h3))
    else $error("mode error flag wrong");
endmodule : wopk_packer_checker

bind wopk_packer wopk_packer_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_i (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .mb_valid_i(mb_valid_i),
  .mb_ready_o(mb_ready_o), .mb_part_i(mb_part_i),
  .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .out_data_o(out_data_o), .out_index_o(out_index_o),
  .out_last_o(out_last_o), .busy_o(busy_o), .mode_err_o(mode_err_o));

/* tb/wopk_sink.sv */
// Consumer model: ready always, at random, or never
`timescale 1ns/10ps
module wopk_sink (
  // Clock
  input wire logic sys_clk_i,
  // Mode: 0 ready, 1 random, 2 stalled
  input wire logic [1:0] mode_i,
  // Stream
  output logic ready_o
);
  initial ready_o = 1'b0;
  always @(negedge sys_clk_i) begin
    ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && $urandom_range(1, 0) == 1);
  end
endmodule : wopk_sink

/* tb/tb_top.sv */
// Self-checking bench for the weight/offset packer
`timescale 1ns/10ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic mb_valid_i = 1'b0;
  logic [1:0] mb_part_i = 2'h0;
  logic [3:0] mb_l0_used_i = 4'h0;
  logic [3:0] mb_l1_used_i = 4'h0;
  logic [191:0] mb_weight_i = '0;
  logic [191:0] mb_offset_i = '0;
  logic mb_ready_o, out_valid_o, out_ready_i, out_last_o, busy_o, mode_err_o;
  logic [31:0] out_data_o;
  logic [3:0] out_index_o;
  logic [1:0] sink_mode = 2'h0;
  logic [35:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  wopk_packer #(.FIFO_DEPTH(16)) wopk_packer_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .mb_valid_i(mb_valid_i),
    .mb_ready_o(mb_ready_o), .mb_part_i(mb_part_i),
    .mb_l0_used_i(mb_l0_used_i), .mb_l1_used_i(mb_l1_used_i),
    .mb_weight_i(mb_weight_i), .mb_offset_i(mb_offset_i),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .out_data_o(out_data_o), .out_index_o(out_index_o),
    .out_last_o(out_last_o), .busy_o(busy_o), .mode_err_o(mode_err_o));
  wopk_sink wopk_sink_i (.sys_clk_i(sys_clk_i), .mode_i(sink_mode),
    .ready_o(out_ready_i));
  task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  function automatic logic [31:0] exp_dw(logic [3:0] idx);
    logic [1:0] s;
    int p;
    logic [15:0] pr[2];
    // Reserved entries first: for partition 3 their byte index would run past the inputs
    if (idx[1:0] == 2'h3) return 32'h0000_0000;
    s = idx[3:2];
    p = mb_part_i == 2'h1 ? s[0] : mb_part_i == 2'h0 ? s[1] : s;
    for (int l = 0; l < 2; l++) begin
      pr[l] = {mb_weight_i[((p * 3 + idx[1:0]) * 2 + l) * 8 +: 8],
        mb_offset_i[((p * 3 + idx[1:0]) * 2 + l) * 8 +: 8]};
    end
    return {mb_l1_used_i[p] ? pr[1] : mb_l0_used_i[p] ? pr[0] : 16'h0000,
      mb_l0_used_i[p] ? pr[0] : mb_l1_used_i[p] ? pr[1] : 16'h0000};
  endfunction : exp_dw
  // Entered at a falling edge; next request goes out as soon as ready
  task automatic send(logic [1:0] part);
    mb_part_i = part;
    mb_l0_used_i = 4'($urandom);
    mb_l1_used_i = 4'($urandom);
    for (int k = 0; k < 6; k++) begin
      mb_weight_i[k * 32 +: 32] = $urandom;
      mb_offset_i[k * 32 +: 32] = $urandom;
    end
    for (int i = 0; i < 16; i++) exp_q.push_back({4'(i), exp_dw(4'(i))});
    while (mb_ready_o !== 1'b1) @(negedge sys_clk_i);
    mb_valid_i = 1'b1;
    @(negedge sys_clk_i);
    mb_valid_i = 1'b0;
    check("mode_err", {35'h0, mode_err_o}, {35'h0, part == 2'h3});
  endtask : send
  task automatic drain(int t);
    sink_mode = 2'h0;
    while (exp_q.size() != 0 || out_valid_o !== 1'b0) @(negedge sys_clk_i);
    $display("test %0d done", t);
  endtask : drain
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      finish_test();
    end else if (reset_n_i && out_valid_o && out_ready_i) begin
      check("last", {35'h0, out_last_o}, {35'h0, out_index_o == 4'hF});
      if (exp_q.size() == 0) check("extra", 36'h0, 36'h1);
      else check("dword", {out_index_o, out_data_o}, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(68));
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    // Each partition code, back to back, under two consumer behaviours (always ready, random)
    for (int m = 0; m < 2; m++) begin
      sink_mode = 2'(m);
      for (int t = 0; t < 8; t++) send(2'(t));
      drain(m);
    end
    // Full buffer must hold the sequencer without losing words
    sink_mode = 2'h2;
    send(2'h2);
    send(2'h1);
    repeat (20) @(negedge sys_clk_i);
    check("stall_busy", {35'h0, busy_o}, 36'h1);
    check("stall_valid", {35'h0, out_valid_o}, 36'h1);
    drain(2);
    finish_test();
  end
endmodule : tb_top
